// File: inc/seg_lcd_pkg.sv
// constants for the segment lcd driver: register map, fields, reset values
// assumes a 32-bit ahb-lite bus with word registers and a 32768 hz low clock
package seg_lcd_pkg;
  localparam int COM_N = 4;
  localparam int SEG_N = 24;
  // printed offsets are register indices; byte address is four times
  localparam logic [11:0] IDX_OSC_OPTION = 12'h088;
  localparam logic [11:0] IDX_DISPLAY_CONTROL = 12'h089;
  localparam logic [11:0] ADDR_OSC_OPTION = IDX_OSC_OPTION << 2;
  localparam logic [11:0] ADDR_DISPLAY_CONTROL = IDX_DISPLAY_CONTROL << 2;
  localparam logic [11:0] ADDR_SCAN_STATUS = 12'h228;
  localparam logic [11:0] ADDR_DOT_BASE = 12'h300;
  localparam logic [11:0] ADDR_DOT_LAST = 12'h35c;
  // display_control fields
  localparam int LADDER_HI_POS = 7;
  localparam int LADDER_LO_POS = 6;
  localparam int BLANK_POS = 5;
  localparam int DRIVE_EN_POS = 3;
  localparam int BIAS_POS = 2;
  localparam logic [7:0] CONTROL_MASK = 8'hec;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // oscillator_option fields
  localparam int OSC_RC_POS = 0;
  localparam logic [7:0] OSC_RESET = 8'h00;
  // frame = low clock / 512, each common gets 128 low clock periods
  localparam int FRAME_DIV = 512;
  localparam int DIV_W = $clog2(FRAME_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FRAME_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = '0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
endpackage

// File: hw/seg_lcd_driver.sv
// segment lcd driver: ahb-lite registers, dot memory, 1/4 duty scan
// assumes hclk at 100 mhz and a slow low clock pin far below hclk;
// analog bias levels are produced outside from the select outputs
//
// Functional notes
// - four common and twenty-four segment outputs, ninety-six dots.
// - commons scanned at 1/4 duty, each active once per frame.
// - bias bit two: clear gives 1/3 bias, set gives 1/2 bias.
// - ladder bits 7:6 pick 400k, 200k, 100k or 50k divider.
// - blank bit five turns every dot off; clear shows pattern.
// - drive enable bit three switches the scan, commons and segments on or off; bias, ladder and oscillator outputs stay driven.
// - control register resets to zero; bits 4, 1, 0 unused.
// - option bit zero: crystal when clear, rc when set, resets zero.
// - frame clock is the low clock divided by 512, 64 hz.
// - dot byte n feeds segment n, bits 0..3 to commons 0..3.
`timescale 1ns/10ps
module seg_lcd_driver
  import seg_lcd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic low_clk_pin,
  output logic [COM_N-1:0] common_line_q,
  output logic [SEG_N-1:0] segment_line_q,
  output logic frame_invert_q,
  output logic bias_ratio_select_q,
  output logic [3:0] ladder_switch_q,
  output logic osc_rc_mode_q
);

  logic [7:0] ctl_q;
  logic [7:0] opt_q;
  logic [COM_N-1:0] dot_q [SEG_N];
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [2:0] lsync_q;
  logic low_level_q;
  logic low_tick;
  logic [DIV_W-1:0] div_q;
  logic [1:0] com_idx;
  logic drive_en;
  logic blank;
  logic [SEG_N-1:0] seg_d;
  logic [31:0] rd_d;
  logic addr_phase;
  logic [11:0] a_lo;
  logic [4:0] dot_idx;
  logic [4:0] wr_idx;

  assign drive_en = ctl_q[DRIVE_EN_POS];
  assign blank = ctl_q[BLANK_POS];
  assign a_lo = haddr[11:0];
  assign dot_idx = 5'((a_lo - ADDR_DOT_BASE) >> 2);
  assign wr_idx = 5'((wr_addr_q - ADDR_DOT_BASE) >> 2);
  assign addr_phase = hsel && hready &&
                      (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // bus answers with zero wait states and always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // write address is caught in the address phase, data lands a cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_q <= a_lo;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= CONTROL_RESET;
      opt_q <= OSC_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == ADDR_DISPLAY_CONTROL)
        ctl_q <= hwdata[7:0] & CONTROL_MASK;
      if (wr_addr_q == ADDR_OSC_OPTION)
        opt_q <= {7'h00, hwdata[OSC_RC_POS]};
    end
  end

  // dot memory keeps only the four common bits of each byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SEG_N; i++)
        dot_q[i] <= 4'h0;
    end else if (wr_pend_q && wr_addr_q >= ADDR_DOT_BASE &&
                 wr_addr_q <= ADDR_DOT_LAST && wr_addr_q[1:0] == 2'b00) begin
      dot_q[wr_idx] <= hwdata[COM_N-1:0];
    end
  end

  // read data is fetched in the address phase so it stands in the data phase
  always_comb begin
    rd_d = 32'h0000_0000;
    if (a_lo == ADDR_DISPLAY_CONTROL)
      rd_d = {24'h000000, ctl_q};
    else if (a_lo == ADDR_OSC_OPTION)
      rd_d = {24'h000000, opt_q};
    else if (a_lo == ADDR_SCAN_STATUS)
      rd_d = {16'h0000, frame_invert_q, 6'h00, div_q};
    else if (a_lo >= ADDR_DOT_BASE && a_lo <= ADDR_DOT_LAST &&
             a_lo[1:0] == 2'b00)
      rd_d = {28'h0000000, dot_q[dot_idx]};
  end

  // limitation: a read pipelined right behind a write to the same register
  // is fetched before that write lands and returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= rd_d;
  end

  // low clock pin: three stages, a change counts when stages two and three
  // agree, which rejects a single sampled glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsync_q <= 3'b000;
      low_level_q <= 1'b0;
    end else begin
      lsync_q <= {lsync_q[1:0], low_clk_pin};
      if (lsync_q[1] == lsync_q[2])
        low_level_q <= lsync_q[2];
    end
  end

  assign low_tick = (lsync_q[1] == lsync_q[2]) && lsync_q[2] && !low_level_q;

  // frame divider: 512 low clock periods, top two bits pick the common
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= DIV_RESET;
      frame_invert_q <= 1'b0;
    end else if (!drive_en) begin
      div_q <= DIV_RESET;
      frame_invert_q <= 1'b0;
    end else if (low_tick) begin
      div_q <= div_q + 1'b1;
      // alternate polarity per frame so the glass sees no dc
      if (div_q == DIV_LAST)
        frame_invert_q <= !frame_invert_q;
    end
  end

  assign com_idx = div_q[DIV_W-1 -: 2];

  always_comb begin
    seg_d = '0;
    for (int s = 0; s < SEG_N; s++)
      seg_d[s] = dot_q[s][com_idx];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      common_line_q <= '0;
      segment_line_q <= '0;
    end else if (!drive_en) begin
      common_line_q <= '0;
      segment_line_q <= '0;
    end else begin
      common_line_q <= 4'(4'h1 << com_idx);
      segment_line_q <= blank ? '0 : seg_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bias_ratio_select_q <= 1'b0;
      ladder_switch_q <= 4'h1;
      osc_rc_mode_q <= 1'b0;
    end else begin
      bias_ratio_select_q <= ctl_q[BIAS_POS];
      // one-hot: bit0 400k, bit1 200k, bit2 100k, bit3 50k
      ladder_switch_q <= 4'(4'h1 << {ctl_q[LADDER_HI_POS],
                                     ctl_q[LADDER_LO_POS]});
      osc_rc_mode_q <= opt_q[OSC_RC_POS];
    end
  end

  a_off_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !drive_en |=> common_line_q == 4'h0 && segment_line_q == '0 &&
                  div_q == DIV_RESET)
    else $error("disabled driver left outputs or scan active");

  a_com_onehot: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_en && $past(drive_en) |-> $onehot(common_line_q))
    else $error("enabled driver does not activate exactly one common");

  a_blank_dark: assert property (
    @(posedge hclk) disable iff (!hresetn)
    blank |=> segment_line_q == '0)
    else $error("blanked display shows a dot");

  a_seg0_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_en && !blank |=>
      segment_line_q[0] == $past(dot_q[0][com_idx]) &&
      common_line_q[$past(com_idx)])
    else $error("segment zero does not follow dot memory");

  a_ladder_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctl_q[7:6] == 2'b11 |=> ladder_switch_q == 4'h8)
    else $error("ladder select 11 did not pick the 50k divider");

  a_bias_sel: assert property (
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> bias_ratio_select_q == $past(ctl_q[BIAS_POS]))
    else $error("bias select did not follow control bit");

  a_ctl_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == ADDR_DISPLAY_CONTROL |=>
      ctl_q == ($past(hwdata[7:0]) & 8'hec))
    else $error("control write stored wrong bits");

  a_frame_wrap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_en && low_tick && div_q == DIV_LAST |=>
      div_q == 9'd0 && frame_invert_q != $past(frame_invert_q))
    else $error("frame did not wrap after 512 low clock periods");

  a_div_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_en && $past(drive_en) && !$past(low_tick) |->
      div_q == $past(div_q))
    else $error("scan advanced without a low clock edge");

  a_rc_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == ADDR_OSC_OPTION |=> ##1
      osc_rc_mode_q == $past(hwdata[0], 2))
    else $error("oscillator type output wrong after option write");

  a_enable_start: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(drive_en) |=> common_line_q == 4'h1 && frame_invert_q == 1'b0)
    else $error("enabled driver did not start at the first common");

  a_com_order: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(drive_en) && $past(drive_en, 2) && $changed(common_line_q) |->
      common_line_q == {$past(common_line_q[2:0]), $past(common_line_q[3])})
    else $error("commons did not advance in order");

  a_seg_last_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_en && !blank |=>
      segment_line_q[SEG_N-1] == $past(dot_q[SEG_N-1][com_idx]))
    else $error("last segment does not follow dot memory");

  a_dot_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == ADDR_DOT_BASE |=>
      dot_q[0] == $past(hwdata[COM_N-1:0]))
    else $error("dot write for segment zero stored wrong bits");

  a_opt_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == ADDR_OSC_OPTION |=>
      opt_q == {7'h00, $past(hwdata[OSC_RC_POS])})
    else $error("option write stored wrong bits");

  a_ctl_unused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |-> (ctl_q & ~CONTROL_MASK) == 8'h00)
    else $error("unimplemented control bit was stored");

  a_tick_single: assert property (
    @(posedge hclk) disable iff (!hresetn)
    low_tick |=> !low_tick)
    else $error("one low clock edge counted twice");

  a_invert_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(drive_en) && !($past(low_tick) && $past(div_q) == DIV_LAST) |->
      $stable(frame_invert_q))
    else $error("frame polarity changed inside a frame");

endmodule

// File: verification/lcd_panel.sv
// passive segment glass model: remembers what each common row showed
// assumes commons one-hot active high and segments valid with them
`timescale 1ns/10ps
module lcd_panel
  import seg_lcd_pkg::*;
(
  input wire logic [COM_N-1:0] common_line,
  input wire logic [SEG_N-1:0] segment_line,
  output logic [COM_N*SEG_N-1:0] image
);
  // a row is latched only while its own common is the sole one driven
  always @(common_line or segment_line) begin
    for (int c = 0; c < COM_N; c++) begin
      if (common_line == COM_N'(1 << c)) begin
        image[c*SEG_N +: SEG_N] = segment_line;
      end
    end
  end
endmodule

// File: verification/testbench.sv
// self-checking bench for the segment lcd driver over ahb-lite
// assumes one slave, so the driver's hreadyout is fed back as hready
`timescale 1ns/10ps
module testbench
  import seg_lcd_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, low_clk = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, frame_inv, bias, osc_rc;
  logic [3:0] ladder, com;
  logic [SEG_N-1:0] seg;
  logic [COM_N*SEG_N-1:0] image, exp_img;
  int num_errors = 0, n_compared = 0;

  seg_lcd_driver i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .low_clk_pin(low_clk),
    .common_line_q(com), .segment_line_q(seg),
    .frame_invert_q(frame_inv), .bias_ratio_select_q(bias),
    .ladder_switch_q(ladder), .osc_rc_mode_q(osc_rc));
  lcd_panel i_panel (.common_line(com), .segment_line(seg), .image(image));

  initial forever #5 hclk = ~hclk;

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
  endtask

  task bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    check(96'(hresp), 96'h0);
    repeat (3) @(posedge hclk);
  endtask

  // each tick is a full low clock period of ten hclk cycles
  task ticks(input int n);
    repeat (n) begin
      low_clk <= 1'b1;
      repeat (5) @(posedge hclk);
      low_clk <= 1'b0;
      repeat (5) @(posedge hclk);
    end
  endtask

  task t_reset;
    bus(ADDR_DISPLAY_CONTROL, 1'b0, 32'h0);
    check(96'(rd), 96'(CONTROL_RESET));
    bus(ADDR_OSC_OPTION, 1'b0, 32'h0);
    check(96'(rd), 96'(OSC_RESET));
    check(96'({ladder, bias, osc_rc, frame_inv, com, seg}),
          96'h8000_0000);
  endtask

  task t_fields;
    for (int v = 0; v < 4; v++) begin
      bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'(v * 64 + (v % 2) * 4));
      check(96'(ladder), 96'(1 << v));
      check(96'(bias), 96'(v % 2));
    end
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'hff);
    bus(ADDR_DISPLAY_CONTROL, 1'b0, 32'h0);
    check(96'(rd), 96'(CONTROL_MASK));
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h0);
    bus(ADDR_OSC_OPTION, 1'b1, 32'hff);
    bus(ADDR_OSC_OPTION, 1'b0, 32'h0);
    check(96'({rd, osc_rc}), 96'h3);
    bus(ADDR_OSC_OPTION, 1'b1, 32'h0);
    check(96'(osc_rc), 96'h0);
    bus(12'h100, 1'b0, 32'h0);
    check(96'(rd), 96'h0);
  endtask

  task t_scan;
    logic [3:0] w;
    for (int n = 0; n < SEG_N; n++) begin
      w = 4'((n * 7 + 3) % 16);
      for (int c = 0; c < COM_N; c++) exp_img[c*SEG_N+n] = w[c];
      bus(ADDR_DOT_BASE + 12'(4 * n), 1'b1, 32'(w));
    end
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h08);
    for (int c = 0; c < COM_N; c++) begin
      check(96'(com), 96'(1 << c));
      ticks(128);
    end
    check(96'({frame_inv, com}), 96'h11);
    check(96'(image), 96'(exp_img));
  endtask

  task t_blank;
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h28);
    check(96'({com, seg}), 96'({4'h1, 24'h0}));
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h08);
    check(96'(seg), 96'(exp_img[SEG_N-1:0]));
    ticks(3);
    bus(ADDR_SCAN_STATUS, 1'b0, 32'h0);
    check(96'(rd), 96'h8003);
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h00);
    check(96'({frame_inv, com, seg}), 96'h0);
    ticks(3);
    bus(ADDR_SCAN_STATUS, 1'b0, 32'h0);
    check(96'(rd), 96'h0);
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h08);
    check(96'(com), 96'h1);
  endtask

  // reset in mid-run must clear registers and outputs again
  task t_rereset;
    bus(ADDR_DISPLAY_CONTROL, 1'b1, 32'h8c);
    bus(ADDR_OSC_OPTION, 1'b1, 32'h1);
    check(96'({ladder, bias, osc_rc}), 96'h13);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check(96'({ladder, bias, osc_rc, frame_inv, com, seg}),
          96'h8000_0000);
    bus(ADDR_DISPLAY_CONTROL, 1'b0, 32'h0);
    check(96'(rd), 96'(CONTROL_RESET));
    bus(ADDR_OSC_OPTION, 1'b0, 32'h0);
    check(96'(rd), 96'(OSC_RESET));
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_fields;
    t_scan;
    t_blank;
    t_rereset;
    wrap_up;
  end
endmodule
